// file: src/drive_status_monitor.sv
/*
 * Supervisory monitor of a motor drive: current windows, analog limit,
 * heatsink threshold, run timer, run-time target, fan, dormant/wakeup,
 * power correction, register port and interrupt.
 * Assumes one clock, synchronous inputs and a 0.1 s tick enable pulse.
 */
`timescale 1ns/100ps
module drive_status_monitor (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [31:0] regRdata,
    input wire logic tickDeci,
    input wire drive_status_pkg::meas_t meas,
    input wire logic driveRunning,
    input wire logic runCmd,
    input wire logic startEvt,
    input wire logic pidSource,
    output drive_status_pkg::flags_t flags,
    output logic stopReq,
    output logic startReq,
    output logic fanOn,
    output logic pidRun,
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////
    // Helpers
    function automatic logic inWindow(input logic [15:0] value, input logic [31:0] cfg);
        logic [16:0] diff;
        diff = (value >= cfg[15:0]) ? {1'b0, value - cfg[15:0]} : {1'b0, cfg[15:0] - value};
        return diff <= {1'b0, cfg[31:16]};
    endfunction

    function automatic logic [15:0] scaleDur(input logic [15:0] dur, input logic [15:0] pct);
        logic [31:0] prod;
        prod = (32'(dur) * 32'(pct)) / drive_status_pkg::AI_FULL_SCALE;
        return (prod > 32'h0000_ffff) ? 16'hffff : prod[15:0];
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Registers
    logic [4:0] ctrl_ff;
    logic [31:0] win1_ff, win2_ff, aiLimit_ff, sleepFreq_ff, sleepDelay_ff, regRdata_ff, power_ff;
    logic [15:0] duration_ff, runTarget_ff, powerCoeff_ff, elapsed_ff, remain_ff, sleepCnt_ff;
    logic [7:0] tempThr_ff;
    logic [6:0] irqStatus_ff, irqMask_ff, flagsQ_ff, flagVec, rise;
    logic [5:0] subTick_ff;
    logic timerDone_ff, timerStop_ff, win1Flag_ff, win2Flag_ff, aiFlag_ff, tempFlag_ff;
    logic runTimeFlag_ff, dormStop_ff, wake_ff, fan_ff, pidRun_ff;
    drive_status_pkg::sleep_t state_ff;
    logic timerEn, fanMode, pidStopEn, sleepOff, win1Now;
    drive_status_pkg::src_t src;
    logic [15:0] durEff;
    assign timerEn = ctrl_ff[drive_status_pkg::CTRL_TIMER_EN_BIT];
    assign fanMode = ctrl_ff[drive_status_pkg::CTRL_FAN_BIT];
    assign pidStopEn = ctrl_ff[drive_status_pkg::CTRL_PID_BIT];
    assign src = drive_status_pkg::src_t'(ctrl_ff[drive_status_pkg::CTRL_SRC_LSB +: 2]);
    assign win1Now = inWindow(meas.current, win1_ff);
    // Register writes
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ctrl_ff <= drive_status_pkg::CTRL_RST;
            win1_ff <= {drive_status_pkg::WIN_AMPL_RST, drive_status_pkg::WIN_CENTRE_RST};
            win2_ff <= {drive_status_pkg::WIN_AMPL_RST, drive_status_pkg::WIN_CENTRE_RST};
            duration_ff <= drive_status_pkg::DURATION_RST;
            aiLimit_ff <= {drive_status_pkg::AI_HIGH_RST, drive_status_pkg::AI_LOW_RST};
            tempThr_ff <= drive_status_pkg::TEMP_THR_RST;
            sleepFreq_ff <= drive_status_pkg::SLEEP_FREQ_RST;
            sleepDelay_ff <= drive_status_pkg::SLEEP_DELAY_RST;
            runTarget_ff <= drive_status_pkg::RUN_TARGET_RST;
            powerCoeff_ff <= drive_status_pkg::POWER_COEFF_RST;
            irqMask_ff <= drive_status_pkg::IRQ_MASK_RST;
        end else if (regWrite) begin
            unique case (regAddr)
                drive_status_pkg::OFS_CTRL: ctrl_ff <= regWdata[4:0];
                drive_status_pkg::OFS_WIN1: win1_ff <= regWdata;
                drive_status_pkg::OFS_WIN2: win2_ff <= regWdata;
                drive_status_pkg::OFS_DURATION: duration_ff <= regWdata[15:0];
                drive_status_pkg::OFS_AI_LIMIT: aiLimit_ff <= regWdata;
                drive_status_pkg::OFS_TEMP_THR: tempThr_ff <= regWdata[7:0];
                drive_status_pkg::OFS_SLEEP_FREQ: sleepFreq_ff <= regWdata;
                drive_status_pkg::OFS_SLEEP_DELAY: sleepDelay_ff <= regWdata;
                drive_status_pkg::OFS_RUN_TARGET: runTarget_ff <= regWdata[15:0];
                drive_status_pkg::OFS_POWER_COEFF: powerCoeff_ff <= regWdata[15:0];
                drive_status_pkg::OFS_IRQ_MASK: irqMask_ff <= regWdata[6:0];
                default: ;
            endcase
        end
    end
    // Register reads, data in the following cycle
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            regRdata_ff <= 32'h0000_0000;
        end else if (regRead) begin
            unique case (regAddr)
                drive_status_pkg::OFS_CTRL: regRdata_ff <= {27'h0, ctrl_ff};
                drive_status_pkg::OFS_WIN1: regRdata_ff <= win1_ff;
                drive_status_pkg::OFS_WIN2: regRdata_ff <= win2_ff;
                drive_status_pkg::OFS_DURATION: regRdata_ff <= {16'h0, duration_ff};
                drive_status_pkg::OFS_AI_LIMIT: regRdata_ff <= aiLimit_ff;
                drive_status_pkg::OFS_TEMP_THR: regRdata_ff <= {24'h0, tempThr_ff};
                drive_status_pkg::OFS_SLEEP_FREQ: regRdata_ff <= sleepFreq_ff;
                drive_status_pkg::OFS_SLEEP_DELAY: regRdata_ff <= sleepDelay_ff;
                drive_status_pkg::OFS_RUN_TARGET: regRdata_ff <= {16'h0, runTarget_ff};
                drive_status_pkg::OFS_POWER_COEFF: regRdata_ff <= {16'h0, powerCoeff_ff};
                drive_status_pkg::OFS_FLAGS: regRdata_ff <= {25'h0, flagVec};
                drive_status_pkg::OFS_REMAINING: regRdata_ff <= {16'h0, remain_ff};
                drive_status_pkg::OFS_POWER_MON: regRdata_ff <= power_ff;
                drive_status_pkg::OFS_IRQ_STATUS: regRdata_ff <= {25'h0, irqStatus_ff};
                drive_status_pkg::OFS_IRQ_MASK: regRdata_ff <= {25'h0, irqMask_ff};
                default: regRdata_ff <= 32'h0000_0000;
            endcase
        end else begin
            regRdata_ff <= 32'h0000_0000;
        end
    end

    assign regRdata = regRdata_ff;

    ////////////////////////////////////////////////////////////////////////
    // Run timer
    always_comb begin
        unique case (src)
            drive_status_pkg::SRC_FIXED: durEff = duration_ff;
            drive_status_pkg::SRC_AI1: durEff = scaleDur(duration_ff, meas.ai1Volt);
            drive_status_pkg::SRC_AI2: durEff = scaleDur(duration_ff, meas.ai2Pct);
            drive_status_pkg::SRC_AI3: durEff = scaleDur(duration_ff, meas.ai3Pct);
        endcase
    end
    // Elapsed run time in tenth minutes
    always_ff @(posedge clk_sys) begin
        if (rst || startEvt) begin
            subTick_ff <= 6'h00;
            elapsed_ff <= 16'h0000;
        end else if (tickDeci && driveRunning) begin
            if (subTick_ff == drive_status_pkg::DECI_PER_TENTH_MIN - 6'h01) begin
                subTick_ff <= 6'h00;
                if (elapsed_ff != 16'hffff) begin
                    elapsed_ff <= elapsed_ff + 16'h0001;
                end
            end else begin
                subTick_ff <= subTick_ff + 6'h01;
            end
        end
    end
    // Expiry, stop request and remaining time
    always_ff @(posedge clk_sys) begin
        if (rst || startEvt) begin
            timerDone_ff <= 1'b0;
            timerStop_ff <= 1'b0;
            remain_ff <= 16'h0000;
        end else begin
            timerStop_ff <= 1'b0;
            remain_ff <= (durEff > elapsed_ff) ? durEff - elapsed_ff : 16'h0000;
            if (tickDeci && timerEn && driveRunning && !timerDone_ff
                && elapsed_ff >= durEff) begin
                timerDone_ff <= 1'b1;
                timerStop_ff <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Comparator flags
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            win1Flag_ff <= 1'b0;
            win2Flag_ff <= 1'b0;
            aiFlag_ff <= 1'b0;
            tempFlag_ff <= 1'b0;
            runTimeFlag_ff <= 1'b0;
        end else if (tickDeci) begin
            win1Flag_ff <= inWindow(meas.current, win1_ff);
            win2Flag_ff <= inWindow(meas.current, win2_ff);
            aiFlag_ff <= (meas.ai1Volt > aiLimit_ff[31:16])
                || (meas.ai1Volt < aiLimit_ff[15:0]);
            tempFlag_ff <= meas.heatsinkTemp >= tempThr_ff;
            if (startEvt) begin
                runTimeFlag_ff <= 1'b0;
            end else if (driveRunning && elapsed_ff >= runTarget_ff) begin
                runTimeFlag_ff <= 1'b1;
            end
        end else if (startEvt) begin
            runTimeFlag_ff <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Dormant and wakeup
    assign sleepOff = (sleepFreq_ff[15:0] == 16'h0000) && (sleepFreq_ff[31:16] == 16'h0000);

    always_ff @(posedge clk_sys) begin
        if (rst || sleepOff) begin
            state_ff <= drive_status_pkg::ST_AWAKE;
            sleepCnt_ff <= 16'h0000;
            dormStop_ff <= 1'b0;
            wake_ff <= 1'b0;
        end else begin
            dormStop_ff <= 1'b0;
            wake_ff <= 1'b0;
            if (tickDeci) begin
                unique case (state_ff)
                    drive_status_pkg::ST_AWAKE: begin
                        if (driveRunning && meas.setFreq <= sleepFreq_ff[31:16]) begin
                            if (sleepCnt_ff >= sleepDelay_ff[31:16]) begin
                                state_ff <= drive_status_pkg::ST_DORMANT;
                                dormStop_ff <= 1'b1;
                                sleepCnt_ff <= 16'h0000;
                            end else begin
                                sleepCnt_ff <= sleepCnt_ff + 16'h0001;
                            end
                        end else begin
                            sleepCnt_ff <= 16'h0000;
                        end
                    end
                    drive_status_pkg::ST_DORMANT: begin
                        if (!runCmd) begin
                            state_ff <= drive_status_pkg::ST_AWAKE;
                            sleepCnt_ff <= 16'h0000;
                        end else if (meas.setFreq >= sleepFreq_ff[15:0]) begin
                            if (sleepCnt_ff >= sleepDelay_ff[15:0]) begin
                                state_ff <= drive_status_pkg::ST_AWAKE;
                                wake_ff <= 1'b1;
                                sleepCnt_ff <= 16'h0000;
                            end else begin
                                sleepCnt_ff <= sleepCnt_ff + 16'h0001;
                            end
                        end else begin
                            sleepCnt_ff <= 16'h0000;
                        end
                    end
                endcase
            end
        end
    end
    // PID hold while dormant
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pidRun_ff <= 1'b1;
        end else begin
            pidRun_ff <= !(pidSource && state_ff == drive_status_pkg::ST_DORMANT
                && !pidStopEn);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Fan and power
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            fan_ff <= 1'b0;
        end else if (fanMode || driveRunning) begin
            fan_ff <= 1'b1;
        end else if (meas.heatsinkTemp > drive_status_pkg::FAN_TEMP_LIMIT) begin
            fan_ff <= 1'b1;
        end else if (meas.heatsinkTemp < drive_status_pkg::FAN_TEMP_LIMIT) begin
            fan_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            power_ff <= 32'h0000_0000;
        end else begin
            power_ff <= (32'(meas.rawPower) * 32'(powerCoeff_ff))
                / drive_status_pkg::POWER_UNITY;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Flags and interrupt
    assign flags = '{dormant: state_ff == drive_status_pkg::ST_DORMANT,
        runTimeHit: runTimeFlag_ff, tempHit: tempFlag_ff, aiLimit: aiFlag_ff,
        timerDone: timerDone_ff, window2: win2Flag_ff, window1: win1Flag_ff};
    assign flagVec = flags;
    assign rise = flagVec & ~flagsQ_ff;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            flagsQ_ff <= 7'h00;
            irqStatus_ff <= 7'h00;
        end else begin
            flagsQ_ff <= flagVec;
            if (regWrite && regAddr == drive_status_pkg::OFS_IRQ_STATUS) begin
                irqStatus_ff <= (irqStatus_ff & ~regWdata[6:0]) | rise;
            end else begin
                irqStatus_ff <= irqStatus_ff | rise;
            end
        end
    end

    assign irq = |(irqStatus_ff & irqMask_ff);
    assign stopReq = timerStop_ff | dormStop_ff;
    assign startReq = wake_ff;
    assign fanOn = fan_ff;
    assign pidRun = pidRun_ff;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    localparam logic [15:0] POWER_COEFF_RST_L = drive_status_pkg::POWER_COEFF_RST;
    a_window_one_flag: assert property (tickDeci |=>
        flags.window1 == $past(win1Now)) else $error("window one flag wrong");
    a_timer_needs_enable: assert property ($rose(flags.timerDone) |->
        $past(timerEn) && $past(driveRunning)) else $error("timer expired while off");
    a_timer_stop_req: assert property ($rose(flags.timerDone) |-> stopReq)
        else $error("expiry without stop request");
    a_start_clears_timer: assert property (startEvt |=>
        elapsed_ff == 16'h0000 && !flags.timerDone) else $error("start did not clear timer");
    a_ai_limit_high: assert property (tickDeci && meas.ai1Volt > aiLimit_ff[31:16]
        |=> flags.aiLimit) else $error("analog limit flag missing");
    a_temp_flag_set: assert property (tickDeci && meas.heatsinkTemp >= tempThr_ff
        |=> flags.tempHit) else $error("temperature flag missing");
    a_fan_while_running: assert property (driveRunning |=> fanOn)
        else $error("fan off while running");
    a_fan_mode_one: assert property (fanMode ##1 fanMode |-> fanOn)
        else $error("fan off in continuous mode");
    a_dormant_stops: assert property ($rose(flags.dormant) |-> stopReq)
        else $error("dormant entry without stop");
    a_wake_needs_cmd: assert property (startReq |->
        $past(runCmd) && $past(flags.dormant)) else $error("wakeup without run command");
    a_sleep_disabled: assert property (sleepOff |=> !flags.dormant)
        else $error("dormant while disabled");
    a_pid_hold: assert property (flags.dormant && pidSource && !pidStopEn
        |=> !pidRun) else $error("pid running while held");
    a_run_target_hit: assert property (tickDeci && !startEvt && driveRunning
        && elapsed_ff >= runTarget_ff |=> flags.runTimeHit) else $error("run target missed");
    a_power_unity: assert property (powerCoeff_ff == POWER_COEFF_RST_L ##1
        powerCoeff_ff == POWER_COEFF_RST_L |-> power_ff == 32'($past(meas.rawPower)))
        else $error("unity power scale wrong");
    a_flags_hold_tick: assert property (!tickDeci && !startEvt |=>
        $stable(win1Flag_ff) && $stable(aiFlag_ff) && $stable(tempFlag_ff))
        else $error("flag moved off tick");

    c_timer_expiry: cover property ($rose(flags.timerDone));
    c_dormant_entry: cover property ($rose(flags.dormant));
    c_wakeup: cover property (startReq);
    c_irq_raised: cover property ($rose(irq));

endmodule

// file: src/drive_status_pkg.sv
/*
 * Constants, register map and carrier types for the drive status monitor.
 * Assumes measured values arrive already scaled in the units noted below.
 */
package drive_status_pkg;

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_WIN1 = 8'h04;
    localparam logic [7:0] OFS_WIN2 = 8'h08;
    localparam logic [7:0] OFS_DURATION = 8'h0c;
    localparam logic [7:0] OFS_AI_LIMIT = 8'h10;
    localparam logic [7:0] OFS_TEMP_THR = 8'h14;
    localparam logic [7:0] OFS_SLEEP_FREQ = 8'h18;
    localparam logic [7:0] OFS_SLEEP_DELAY = 8'h1c;
    localparam logic [7:0] OFS_RUN_TARGET = 8'h20;
    localparam logic [7:0] OFS_POWER_COEFF = 8'h24;
    localparam logic [7:0] OFS_FLAGS = 8'h28;
    localparam logic [7:0] OFS_REMAINING = 8'h2c;
    localparam logic [7:0] OFS_POWER_MON = 8'h30;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h34;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h38;

    // Control register fields
    localparam int unsigned CTRL_TIMER_EN_BIT = 0;
    localparam int unsigned CTRL_SRC_LSB = 1;
    localparam int unsigned CTRL_FAN_BIT = 3;
    localparam int unsigned CTRL_PID_BIT = 4;
    localparam int unsigned CTRL_W = 5;

    // Reset values: current 0.1 %, voltage 0.01 V, temp 1 C, coeff 0.01 %
    localparam logic [4:0] CTRL_RST = 5'h00;
    localparam logic [15:0] WIN_CENTRE_RST = 16'h03e8;
    localparam logic [15:0] WIN_AMPL_RST = 16'h0000;
    localparam logic [15:0] DURATION_RST = 16'h0000;
    localparam logic [15:0] AI_LOW_RST = 16'h0136;
    localparam logic [15:0] AI_HIGH_RST = 16'h02a8;
    localparam logic [7:0] TEMP_THR_RST = 8'h4b;
    localparam logic [31:0] SLEEP_FREQ_RST = 32'h0000_0000;
    localparam logic [31:0] SLEEP_DELAY_RST = 32'h0000_0000;
    localparam logic [15:0] RUN_TARGET_RST = 16'h0000;
    localparam logic [15:0] POWER_COEFF_RST = 16'h2710;
    localparam logic [6:0] IRQ_MASK_RST = 7'h00;

    // Scaling and timing
    localparam logic [7:0] FAN_TEMP_LIMIT = 8'h28;
    localparam logic [31:0] AI_FULL_SCALE = 32'h0000_03e8;
    localparam logic [31:0] POWER_UNITY = 32'h0000_2710;
    localparam logic [5:0] DECI_PER_TENTH_MIN = 6'h3c;

    typedef enum logic [1:0] {
        SRC_FIXED = 2'h0,
        SRC_AI1 = 2'h1,
        SRC_AI2 = 2'h2,
        SRC_AI3 = 2'h3
    } src_t;

    typedef enum logic [1:0] {
        ST_AWAKE = 2'b01,
        ST_DORMANT = 2'b10
    } sleep_t;

    typedef struct packed {
        logic [15:0] current;
        logic [15:0] ai1Volt;
        logic [15:0] ai2Pct;
        logic [15:0] ai3Pct;
        logic [7:0] heatsinkTemp;
        logic [15:0] setFreq;
        logic [15:0] rawPower;
    } meas_t;

    typedef struct packed {
        logic dormant;
        logic runTimeHit;
        logic tempHit;
        logic aiLimit;
        logic timerDone;
        logic window2;
        logic window1;
    } flags_t;

endpackage

// file: test/drive_model.sv
/* Drive model: run state and 0.1 s tick of the power stage.
   Assumes one-cycle stop and start request pulses from the monitor. */
`timescale 1ns/100ps
module drive_model (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic startEvt,
    input wire logic stopReq,
    input wire logic startReq,
    output logic driveRunning,
    output logic tickDeci
);
    logic [1:0] div_ff;
    always_ff @(posedge clk_sys) begin
        div_ff <= rst ? 2'h0 : div_ff + 2'h1;
        tickDeci <= !rst && div_ff == 2'h3;
    end
    always_ff @(posedge clk_sys) begin
        if (rst || stopReq) driveRunning <= 1'b0;
        else if (startEvt || startReq) driveRunning <= 1'b1;
    end
endmodule

// file: test/drive_status_monitor_test.sv
/* Bench of the drive status monitor.
   Assumes the drive model supplies ticks and run state. */
`timescale 1ns/100ps
module drive_status_monitor_test;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [7:0] regAddr = 8'h00;
    logic [31:0] regWdata = 32'h0;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic runCmd = 1'b0;
    logic startEvt = 1'b0;
    logic pidSource = 1'b0;
    drive_status_pkg::meas_t meas;
    drive_status_pkg::flags_t flags;
    logic [31:0] regRdata;
    logic tickDeci, driveRunning, stopReq, startReq, fanOn, pidRun, irq;
    int miscompares = 0;
    int checks_done = 0;
    always #4 clk_sys = ~clk_sys;
    drive_model model (.clk_sys(clk_sys), .rst(rst), .startEvt(startEvt), .stopReq(stopReq),
        .startReq(startReq), .driveRunning(driveRunning), .tickDeci(tickDeci));
    drive_status_monitor dut (.clk_sys(clk_sys), .rst(rst), .regAddr(regAddr),
        .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
        .tickDeci(tickDeci), .meas(meas), .driveRunning(driveRunning), .runCmd(runCmd),
        .startEvt(startEvt), .pidSource(pidSource), .flags(flags), .stopReq(stopReq),
        .startReq(startReq), .fanOn(fanOn), .pidRun(pidRun), .irq(irq));
    ////////////////////////////////////////////////////////////////////////
    task chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            miscompares++;
            $display("BAD t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task chkb(input logic g, input logic e);
        chk({31'h0, g}, {31'h0, e});
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge clk_sys);
        regWrite <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk_sys);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk_sys);
        regRead <= 1'b0;
        @(negedge clk_sys);
        chk(regRdata, e);
        @(posedge clk_sys);
    endtask
    task ticks(input int n);
        repeat (n * 4) @(posedge clk_sys);
    endtask
    task waitf(input int i, input logic v);
        for (int k = 0; k < 3000 && flags[i] !== v; k++) @(posedge clk_sys);
        @(negedge clk_sys);
        chkb(flags[i], v);
        @(posedge clk_sys);
    endtask
    task start;
        @(posedge clk_sys);
        startEvt <= 1'b1;
        @(posedge clk_sys);
        startEvt <= 1'b0;
    endtask
    task test_done;
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        #400000;
        miscompares++;
        test_done;
    end
    initial begin
        meas = '0;
        meas.ai1Volt = 16'h01f4;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        rd(drive_status_pkg::OFS_WIN2, 32'h0000_03e8);
        rd(drive_status_pkg::OFS_AI_LIMIT, 32'h02a8_0136);
        rd(drive_status_pkg::OFS_TEMP_THR, 32'h0000_004b);
        rd(drive_status_pkg::OFS_POWER_COEFF, 32'h0000_2710);
        rd(8'h3c, 32'h0);
        rd(drive_status_pkg::OFS_FLAGS, 32'h0);
        $display("reset test done");
        meas.current <= 16'h03e8;
        ticks(3);
        rd(drive_status_pkg::OFS_FLAGS, 32'h03);
        wr(drive_status_pkg::OFS_WIN1, 32'h0005_03e8);
        meas.current <= 16'h03ed;
        ticks(3);
        rd(drive_status_pkg::OFS_FLAGS, 32'h01);
        meas.current <= 16'h03ee;
        ticks(3);
        rd(drive_status_pkg::OFS_FLAGS, 32'h0);
        $display("window test done");
        wr(drive_status_pkg::OFS_IRQ_MASK, 32'h08);
        meas.ai1Volt <= 16'h0135;
        ticks(3);
        rd(drive_status_pkg::OFS_FLAGS, 32'h08);
        chkb(irq, 1'b1);
        meas.ai1Volt <= 16'h0136;
        ticks(3);
        rd(drive_status_pkg::OFS_FLAGS, 32'h0);
        wr(drive_status_pkg::OFS_IRQ_STATUS, 32'h08);
        @(posedge clk_sys);
        chkb(irq, 1'b0);
        meas.ai1Volt <= 16'h02a9;
        ticks(3);
        rd(drive_status_pkg::OFS_FLAGS, 32'h08);
        meas.ai1Volt <= 16'h01f4;
        meas.heatsinkTemp <= 8'h4b;
        ticks(3);
        rd(drive_status_pkg::OFS_FLAGS, 32'h10);
        chkb(fanOn, 1'b1);
        meas.heatsinkTemp <= 8'h27;
        ticks(3);
        rd(drive_status_pkg::OFS_FLAGS, 32'h0);
        chkb(fanOn, 1'b0);
        wr(drive_status_pkg::OFS_CTRL, 32'h08);
        ticks(1);
        chkb(fanOn, 1'b1);
        $display("limit test done");
        wr(drive_status_pkg::OFS_DURATION, 32'h1);
        wr(drive_status_pkg::OFS_RUN_TARGET, 32'h1);
        wr(drive_status_pkg::OFS_CTRL, 32'h01);
        start;
        ticks(2);
        chkb(fanOn, 1'b1);
        rd(drive_status_pkg::OFS_REMAINING, 32'h1);
        waitf(2, 1'b1);
        chkb(flags.runTimeHit, 1'b1);
        chkb(driveRunning, 1'b0);
        rd(drive_status_pkg::OFS_REMAINING, 32'h0);
        start;
        waitf(2, 1'b0);
        wr(drive_status_pkg::OFS_DURATION, 32'h64);
        wr(drive_status_pkg::OFS_CTRL, 32'h03);
        rd(drive_status_pkg::OFS_REMAINING, 32'h32);
        wr(drive_status_pkg::OFS_CTRL, 32'h0);
        $display("timer test done");
        meas.setFreq <= 16'h0100;
        runCmd <= 1'b1;
        wr(drive_status_pkg::OFS_SLEEP_FREQ, 32'h0100_0200);
        waitf(6, 1'b1);
        chkb(driveRunning, 1'b0);
        pidSource <= 1'b1;
        ticks(1);
        chkb(pidRun, 1'b0);
        pidSource <= 1'b0;
        meas.setFreq <= 16'h0200;
        waitf(6, 1'b0);
        ticks(1);
        chkb(driveRunning, 1'b1);
        wr(drive_status_pkg::OFS_SLEEP_FREQ, 32'h0);
        meas.setFreq <= 16'h0000;
        ticks(5);
        chkb(flags.dormant, 1'b0);
        $display("dormant test done");
        meas.rawPower <= 16'h0064;
        wr(drive_status_pkg::OFS_POWER_COEFF, 32'h4e20);
        ticks(1);
        rd(drive_status_pkg::OFS_POWER_MON, 32'hc8);
        $display("power test done");
        test_done;
    end
endmodule
